// ===== common/psl_pkg.sv
package psl_pkg;
    // framing and address layout of the link
    localparam int BYTE_BITS      = 8;
    localparam int BIT_CNT_W      = 3;
    localparam int ADDR_PORT_HI   = 7;
    localparam int ADDR_PORT_LO   = 6;
    localparam int ADDR_R1_HI     = 5;
    localparam int ADDR_R1_LO     = 3;
    localparam int ADDR_R2_HI     = 2;
    localparam int ADDR_R2_LO     = 0;
    localparam logic [2:0] LAST_BIT     = 3'h7;
    localparam logic [2:0] BIT_CNT_RST  = 3'h0;
    localparam logic [7:0] BYTE_RST     = 8'h00;
    localparam logic [7:0] BYTE_CNT_MAX = 8'hFF;
    localparam logic [1:0] SYNC_RST     = 2'h0;
    // link timing, in ns and in system clocks
    localparam int SYS_CLK_NS     = 10;
    localparam int LINK_CLK_NS    = 80;
    localparam int LINK_HALF_CLKS = (LINK_CLK_NS / 2) / SYS_CLK_NS;
    typedef enum logic [1:0]
    {
        PSL_IDLE    = 2'b00,
        PSL_ADDR    = 2'b01,
        PSL_DATA    = 2'b10,
        PSL_IGNORE  = 2'b11
    } psl_state_t;
endpackage

// ===== hw/psl_sync.sv
`timescale 1ns/10ps
// two-stage synchroniser for one pin
module psl_sync
#(
    parameter bit RST_VAL = 1'b0
)
(
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic din,
    output logic      dout
);
    logic meta_reg;

    // first stage is read only by the second
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            // reset to the pin's idle level so no false edge follows reset
            meta_reg <= RST_VAL;
            dout     <= RST_VAL;
        end
        else
        begin
            meta_reg <= din;
            dout     <= meta_reg;
        end
    end
endmodule

// ===== hw/psl_card.sv
`timescale 1ns/10ps
// Behaviour
// [RQ1] master alone drives serial clock; it times both data directions
// [RQ2] master alone drives select; the card only reads it
// [RQ3] asserted select puts the card in selected state, acting on commands
// [RQ4] master asserts select first, then clock and command bits together
// [RQ5] with several cards, first command byte is the card address
// [RQ6] direct link: selected on select alone, no clock or byte needed
// [RQ7] while selected both bit streams move together on the shared clock
// [RQ8] transaction lasts exactly while select stays asserted
// [RQ9] commands arrive on transmit line, replies leave on receive line
// [RQ10] one card per master port, point to point, no shared lines
// [RQ11] address byte: port bits 7:6, router one 5:3, router two 2:0
// [RQ12] deselect clears bit and byte counters and stops new reply data
module psl_card
#(
    parameter bit MULTI_CARD = 1'b0,
    parameter logic [7:0] MY_ADDR = 8'h00
)
(
    input  wire logic       SYS_CLK,
    input  wire logic       RST_N,
    input  wire logic       LINK_SCLK,
    input  wire logic       LINK_SEL_N,
    input  wire logic       LINK_CMD,
    output logic            LINK_REPLY,
    output logic            LINK_REPLY_OE,
    output logic            SELECTED,
    output logic            ADDR_MATCH,
    output logic [7:0]      RX_BYTE,
    output logic            RX_VALID,
    output logic [7:0]      RX_COUNT,
    input  wire logic [7:0] TX_BYTE,
    output logic            TX_TAKEN
);
    // ========================================================================
    // pin synchronisers
    // ========================================================================
    logic sclk_s;
    logic sel_n_s;
    logic cmd_s;
    logic sclk_d_reg;

    // clock parks high and select idles high: both stages reset to that level
    psl_sync #(.RST_VAL(1'b1)) u_sclk
    (
        .clk   (SYS_CLK),
        .rst_n (RST_N),
        .din   (LINK_SCLK),
        .dout  (sclk_s)
    );
    psl_sync #(.RST_VAL(1'b1)) u_sel
    (
        .clk   (SYS_CLK),
        .rst_n (RST_N),
        .din   (LINK_SEL_N),
        .dout  (sel_n_s)
    ); // RQ2
    psl_sync u_cmd  (.clk(SYS_CLK), .rst_n(RST_N), .din(LINK_CMD), .dout(cmd_s)); // RQ9

    // ========================================================================
    // edge detection
    // ========================================================================
    wire sel_now  = ~sel_n_s;
    wire rise     = sclk_s & ~sclk_d_reg & sel_now; // RQ1
    wire fall     = ~sclk_s & sclk_d_reg & sel_now;

    // idle serial clock is high; reset value matches so no edge after reset
    always_ff @(posedge SYS_CLK or negedge RST_N)
    begin
        if (!RST_N)
            sclk_d_reg <= 1'b1;
        else
            sclk_d_reg <= sclk_s;
    end

    // address field helpers for a routed system
    function automatic logic [1:0] addr_port(input logic [7:0] a);
        addr_port = a[psl_pkg::ADDR_PORT_HI:psl_pkg::ADDR_PORT_LO]; // RQ11
    endfunction
    function automatic logic [2:0] addr_r1(input logic [7:0] a);
        addr_r1 = a[psl_pkg::ADDR_R1_HI:psl_pkg::ADDR_R1_LO]; // RQ11
    endfunction
    function automatic logic [2:0] addr_r2(input logic [7:0] a);
        addr_r2 = a[psl_pkg::ADDR_R2_HI:psl_pkg::ADDR_R2_LO]; // RQ11
    endfunction

    // ========================================================================
    // state
    // ========================================================================
    psl_pkg::psl_state_t state_reg;
    psl_pkg::psl_state_t state_next;
    logic [2:0] bit_cnt_reg;
    logic [7:0] shift_in_reg;
    logic [7:0] shift_out_reg;
    wire        byte_done = rise && (bit_cnt_reg == psl_pkg::LAST_BIT);
    wire [7:0]  byte_in   = {shift_in_reg[6:0], cmd_s};
    wire        addr_ok   = (addr_port(byte_in) == addr_port(MY_ADDR))
                          && (addr_r1(byte_in) == addr_r1(MY_ADDR))
                          && (addr_r2(byte_in) == addr_r2(MY_ADDR));

    // selected on select alone; the address byte only filters in multi-card
    always_comb
    begin
        state_next = state_reg;
        unique case (state_reg)
            psl_pkg::PSL_IDLE:
                if (sel_now)
                    state_next = MULTI_CARD ? psl_pkg::PSL_ADDR : psl_pkg::PSL_DATA; // RQ6
            psl_pkg::PSL_ADDR:
                if (byte_done)
                    state_next = addr_ok ? psl_pkg::PSL_DATA : psl_pkg::PSL_IGNORE; // RQ5
            psl_pkg::PSL_DATA:
                state_next = psl_pkg::PSL_DATA;
            psl_pkg::PSL_IGNORE:
                state_next = psl_pkg::PSL_IGNORE;
        endcase
        if (!sel_now)
            state_next = psl_pkg::PSL_IDLE; // RQ8
    end

    always_ff @(posedge SYS_CLK or negedge RST_N)
    begin
        if (!RST_N)
            state_reg <= psl_pkg::PSL_IDLE;
        else
            state_reg <= state_next; // RQ3
    end

    // ========================================================================
    // bit counter and receive shifter
    // ========================================================================
    // counters cleared while deselected so a broken frame never skews the next
    always_ff @(posedge SYS_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            bit_cnt_reg  <= psl_pkg::BIT_CNT_RST;
            shift_in_reg <= psl_pkg::BYTE_RST;
        end
        else if (!sel_now)
        begin
            bit_cnt_reg  <= psl_pkg::BIT_CNT_RST; // RQ12
            shift_in_reg <= psl_pkg::BYTE_RST;
        end
        else if (rise)
        begin
            bit_cnt_reg  <= bit_cnt_reg + 3'h1;
            shift_in_reg <= byte_in; // RQ7
        end
    end

    // received bytes after the address stage, with a saturating byte count
    always_ff @(posedge SYS_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            RX_BYTE  <= psl_pkg::BYTE_RST;
            RX_VALID <= 1'b0;
            RX_COUNT <= psl_pkg::BYTE_RST;
        end
        else
        begin
            RX_VALID <= byte_done && state_reg == psl_pkg::PSL_DATA; // RQ3
            if (byte_done && state_reg == psl_pkg::PSL_DATA)
                RX_BYTE <= byte_in;
            if (!sel_now)
                RX_COUNT <= psl_pkg::BYTE_RST; // RQ12
            else if (byte_done && state_reg == psl_pkg::PSL_DATA
                     && RX_COUNT != psl_pkg::BYTE_CNT_MAX)
                RX_COUNT <= RX_COUNT + 8'h01;
        end
    end

    // ========================================================================
    // reply shifter
    // ========================================================================
    // reply changes on falling edges so the master samples it on rising ones
    wire load_tx = fall && (bit_cnt_reg == psl_pkg::BIT_CNT_RST);
    always_ff @(posedge SYS_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            shift_out_reg <= psl_pkg::BYTE_RST;
            LINK_REPLY    <= 1'b0;
            TX_TAKEN      <= 1'b0;
        end
        else if (state_reg != psl_pkg::PSL_DATA || !sel_now)
        begin
            shift_out_reg <= psl_pkg::BYTE_RST; // RQ12
            LINK_REPLY    <= 1'b0;
            TX_TAKEN      <= 1'b0;
        end
        else
        begin
            TX_TAKEN <= load_tx;
            if (load_tx)
            begin
                LINK_REPLY    <= TX_BYTE[7]; // RQ9
                shift_out_reg <= {TX_BYTE[6:0], 1'b0};
            end
            else if (fall)
            begin
                LINK_REPLY    <= shift_out_reg[7]; // RQ7
                shift_out_reg <= {shift_out_reg[6:0], 1'b0};
            end
        end
    end

    // point to point: the card drives its reply line whenever addressed
    always_ff @(posedge SYS_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            LINK_REPLY_OE <= 1'b0;
            SELECTED      <= 1'b0;
            ADDR_MATCH    <= 1'b0;
        end
        else
        begin
            LINK_REPLY_OE <= sel_now && state_reg == psl_pkg::PSL_DATA; // RQ10
            SELECTED      <= sel_now; // RQ6
            ADDR_MATCH    <= sel_now && state_reg == psl_pkg::PSL_DATA;
        end
    end

    // ========================================================================
    // checks
    // ========================================================================
    sel_follow_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // RQ6
        $fell(sel_n_s) |=> SELECTED)
        else $error("select not seen one cycle later");
    desel_drop_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // RQ8
        $rose(sel_n_s) |=> !SELECTED ##1 !LINK_REPLY_OE)
        else $error("card stayed selected after release");
    cnt_clear_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // RQ12
        sel_n_s |=> (bit_cnt_reg == psl_pkg::BIT_CNT_RST) && (RX_COUNT == psl_pkg::BYTE_RST))
        else $error("counters not cleared when deselected");
    reply_quiet_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // RQ12
        sel_n_s ##1 sel_n_s |=> !LINK_REPLY && !LINK_REPLY_OE)
        else $error("reply driven while deselected");
    state_enter_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // RQ3
        (state_reg == psl_pkg::PSL_IDLE && !sel_n_s) |=> state_reg != psl_pkg::PSL_IDLE)
        else $error("selected state not entered");
    addr_gate_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // RQ5
        (state_reg == psl_pkg::PSL_ADDR && byte_done && !addr_ok && sel_now)
        |=> state_reg == psl_pkg::PSL_IGNORE ##1 !RX_VALID)
        else $error("foreign address accepted");
    rx_byte_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // RQ7
        (byte_done && state_reg == psl_pkg::PSL_DATA) |=> RX_VALID && RX_BYTE == $past(byte_in))
        else $error("received byte lost");
    bit_step_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // RQ1
        (rise && sel_now) |=> bit_cnt_reg == $past(bit_cnt_reg) + 3'h1 || !sel_now)
        else $error("bit counter missed a clock edge");
    tx_take_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // RQ9
        TX_TAKEN |-> LINK_REPLY == $past(TX_BYTE[7]))
        else $error("reply msb not sent on load");
endmodule

// ===== bench/psl_master.sv
`timescale 1ns/10ps
// =====================================================
// master end of the link: owns clock, select and command line
module psl_master
#(
    parameter int HALF = 4
)
(
    input  wire logic clk,
    input  wire logic reply,
    output logic      sclk,
    output logic      sel_n,
    output logic      cmd
);
    // clock parks high between frames and never runs outside one
    initial
    begin
        sclk  = 1'b1;
        sel_n = 1'b1;
        cmd   = 1'b0;
    end

    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask

    // select alone; caller waits before the first clock edge
    task automatic open_frame();
        tick(1);
        sel_n = 1'b0;
    endtask

    // released command line shows the inverse, never a stale level
    task automatic close_frame();
        sel_n = 1'b1;
        cmd   = ~cmd;
        tick(HALF);
    endtask

    // msb first; reply read late in the high phase, after the card settled
    task automatic xfer(input logic [7:0] tx, input int nbits, output logic [7:0] rx);
        rx = 8'h00;
        for (int i = 7; i > 7 - nbits; i--)
        begin
            sclk = 1'b0;
            cmd  = tx[i];
            tick(HALF);
            sclk = 1'b1;
            tick(HALF - 1);
            rx[i] = reply;
            tick(1);
        end
    endtask
endmodule

// ===== bench/psl_card_tb_top.sv
`timescale 1ns/10ps
`define CHK(nm, exp, got) begin num_checks++; if ((got) !== (exp)) begin err_count++; $display("CHECK FAILED %s exp %h got %h", nm, exp, got); end end
module psl_card_tb_top;
    // =====================================================
    // card address: port 2, router one 5, router two 3
    localparam logic [7:0] CARD_ADDR = 8'hAB;
    logic       sys_clk;
    logic       rst_n;
    logic       sclk;
    logic       sel_n;
    logic       cmd;
    logic       reply;
    logic       reply_oe;
    logic       reply_line;
    logic       selected;
    logic       addr_match;
    logic [7:0] rx_byte;
    logic       rx_valid;
    logic [7:0] rx_count;
    logic [7:0] tx_byte;
    logic       tx_taken;
    logic       d_sel;
    logic       d_oe;
    logic       d_match;
    logic [7:0] d_byte;
    logic [7:0] d_count;
    logic [7:0] r;
    logic [7:0] got_q[$];
    int         takes;
    int         err_count;
    int         num_checks;

    // =====================================================
    // clock, reset and the wire seen by the master (pulled up when idle)
    initial sys_clk = 1'b0;
    always #5 sys_clk = ~sys_clk;
    assign reply_line = reply_oe ? reply : 1'b1;

    psl_card #(.MULTI_CARD(1'b1), .MY_ADDR(CARD_ADDR)) dut
    (
        .SYS_CLK       (sys_clk),
        .RST_N         (rst_n),
        .LINK_SCLK     (sclk),
        .LINK_SEL_N    (sel_n),
        .LINK_CMD      (cmd),
        .LINK_REPLY    (reply),
        .LINK_REPLY_OE (reply_oe),
        .SELECTED      (selected),
        .ADDR_MATCH    (addr_match),
        .RX_BYTE       (rx_byte),
        .RX_VALID      (rx_valid),
        .RX_COUNT      (rx_count),
        .TX_BYTE       (tx_byte),
        .TX_TAKEN      (tx_taken)
    );

    // direct-link card on the same master lines; it never answers the master
    psl_card #(.MULTI_CARD(1'b0), .MY_ADDR(CARD_ADDR)) dut_direct
    (
        .SYS_CLK       (sys_clk),
        .RST_N         (rst_n),
        .LINK_SCLK     (sclk),
        .LINK_SEL_N    (sel_n),
        .LINK_CMD      (cmd),
        .LINK_REPLY    (),
        .LINK_REPLY_OE (d_oe),
        .SELECTED      (d_sel),
        .ADDR_MATCH    (d_match),
        .RX_BYTE       (d_byte),
        .RX_VALID      (),
        .RX_COUNT      (d_count),
        .TX_BYTE       (tx_byte),
        .TX_TAKEN      ()
    );

    psl_master #(.HALF(psl_pkg::LINK_HALF_CLKS)) master
    (
        .clk   (sys_clk),
        .reply (reply_line),
        .sclk  (sclk),
        .sel_n (sel_n),
        .cmd   (cmd)
    );

    // collect every delivered byte; the pulse stands one cycle only
    always @(posedge sys_clk)
    begin
        if (rx_valid === 1'b1)
            got_q.push_back(rx_byte);
        if (tx_taken === 1'b1)
            takes++;
    end

    // =====================================================
    // scenarios
    task automatic t_frame();
        got_q.delete();
        takes = 0;
        master.open_frame();
        repeat (2) @(negedge sys_clk);
        `CHK("selected early", 1'b0, selected)
        @(negedge sys_clk);
        `CHK("selected", 1'b1, selected)
        `CHK("match before byte", 1'b0, addr_match)
        `CHK("direct selected", 1'b1, d_sel)
        @(negedge sys_clk);
        `CHK("direct data phase", 1'b1, d_match)
        `CHK("direct oe", 1'b1, d_oe)
        master.xfer(CARD_ADDR, 8, r);
        `CHK("match", 1'b1, addr_match)
        `CHK("direct first byte", CARD_ADDR, d_byte)
        tx_byte = 8'h5A;
        master.xfer(8'h3C, 8, r);
        `CHK("reply oe", 1'b1, reply_oe)
        `CHK("reply 0", 8'h5A, r)
        tx_byte = 8'hC3;
        master.xfer(8'hA5, 8, r);
        `CHK("reply 1", 8'hC3, r)
        `CHK("tx taken", 1'b1, takes >= 2)
        `CHK("rx count", 8'h02, rx_count)
        `CHK("direct count", 8'h03, d_count)
        `CHK("rx 0", 8'h3C, got_q[0])
        `CHK("rx 1", 8'hA5, got_q[1])
        // half a byte then deselect: must be dropped
        master.xfer(8'hFF, 4, r);
        master.close_frame();
        repeat (4) @(negedge sys_clk);
        `CHK("deselected", 1'b0, selected)
        `CHK("count cleared", 8'h00, rx_count)
        `CHK("direct cleared", 8'h00, d_count)
        `CHK("oe off", 1'b0, reply_oe)
        `CHK("partial dropped", 2, got_q.size())
    endtask

    // one field wrong at a time: port, router one, router two
    task automatic t_wrong();
        logic [7:0] bad[3] = '{8'h6B, 8'h93, 8'hAC};
        foreach (bad[i])
        begin
            got_q.delete();
            master.open_frame();
            repeat (4) @(negedge sys_clk);
            master.xfer(bad[i], 8, r);
            `CHK("no match", 1'b0, addr_match)
            master.xfer(8'h66, 8, r);
            `CHK("ignored", 0, got_q.size())
            `CHK("direct takes all", 8'h66, d_byte)
            `CHK("silent", 1'b0, reply_oe)
            master.close_frame();
            repeat (4) @(negedge sys_clk);
        end
    endtask

    task automatic end_of_test();
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // =====================================================
    // main sequence; the second good frame proves recovery after ignored ones
    initial
    begin
        rst_n      = 1'b0;
        tx_byte    = 8'h00;
        err_count  = 0;
        num_checks = 0;
        repeat (6) @(negedge sys_clk);
        `CHK("reset sel", 1'b0, selected)
        `CHK("reset oe", 1'b0, reply_oe)
        `CHK("reset count", 8'h00, rx_count)
        rst_n = 1'b1;
        repeat (3) @(negedge sys_clk);
        t_frame();
        t_wrong();
        t_frame();
        end_of_test();
    end

    // under a thousand clocks suffice; this cuts a hang
    initial
    begin
        #100us;
        err_count++;
        end_of_test();
    end
endmodule
